//--- svs_pkg.sv
// constants for the supply voltage supervisor
package svs_pkg;
	// serial frame layout
	localparam int FRAME_BITS = 32;
	localparam int ADDR_BITS = 8;
	localparam logic [5:0] CTRL_ADDR = 6'h03;
	localparam int WR_FLAG_POS = 31;
	localparam int CNT_W = 6;
	// control register field positions
	localparam int REG_LOCK_POS = 23;
	localparam int BAT_LOCK_POS = 22;
	localparam int REG_OV_EN_POS = 21;
	localparam int REG_UV_EN_POS = 20;
	localparam int BAT_OV_EN_POS = 19;
	localparam int BAT_UV_EN_POS = 18;
	localparam int THR_W = 10;
	// control register reset value and writable bits
	localparam logic [23:0] CTRL_RESET = 24'hFC0000;
	localparam logic [23:0] CTRL_WMASK = 24'hFC03FF;
	localparam logic [9:0] THR_OFF = 10'h000;
endpackage

//--- svs_serial_port.sv
// serial slave port carrying the supervision control register
module svs_serial_port (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// serial pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_sdi,
	output logic o_sdo,
	// register side
	input wire logic [23:0] i_ctrl,
	output logic o_wr_stb,
	output logic [23:0] o_wdata
);
	logic sck_q, next_sck_q, cs_q, next_cs_q, sdo, next_sdo, wr_stb, next_wr_stb;
	logic [31:0] shift, next_shift;
	logic [23:0] txd, next_txd, wdata, next_wdata;
	logic [svs_pkg::CNT_W-1:0] cnt, next_cnt;
	logic rise, fall, cs_end;
	logic [23:0] rd;

	always_comb
	begin
		rise = i_sck & ~sck_q;
		fall = ~i_sck & sck_q;
		cs_end = i_cs_n & ~cs_q;
		rd = (shift[5:0] == svs_pkg::CTRL_ADDR) ? i_ctrl : 24'h000000;
		next_sck_q = i_sck;
		next_cs_q = i_cs_n;
		next_shift = shift;
		next_cnt = cnt;
		next_txd = txd;
		next_sdo = sdo;
		next_wr_stb = 1'b0;
		next_wdata = wdata;
		if (i_cs_n)
		begin
			next_cnt = '0;
			next_sdo = 1'b0;
		end
		else
		begin
			if (rise)
			begin
				next_shift = {shift[30:0], i_sdi};
				if (cnt <= 6'(svs_pkg::FRAME_BITS))
					next_cnt = cnt + 6'h01;
			end
			if (fall && cnt == 6'(svs_pkg::ADDR_BITS))
			begin
				next_sdo = rd[23];
				next_txd = {rd[22:0], 1'b0};
			end
			else if (fall && cnt > 6'(svs_pkg::ADDR_BITS))
			begin
				next_sdo = txd[23];
				next_txd = {txd[22:0], 1'b0};
			end
		end
		// new value takes effect only when chip select returns high
		if (cs_end && cnt == 6'(svs_pkg::FRAME_BITS) && shift[svs_pkg::WR_FLAG_POS]
			&& shift[29:24] == svs_pkg::CTRL_ADDR)
		begin
			next_wr_stb = 1'b1;
			next_wdata = shift[23:0];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			shift <= '0;
			cnt <= '0;
			txd <= '0;
			sdo <= 1'b0;
			wr_stb <= 1'b0;
			wdata <= '0;
		end
		else
		begin
			sck_q <= next_sck_q;
			cs_q <= next_cs_q;
			shift <= next_shift;
			cnt <= next_cnt;
			txd <= next_txd;
			sdo <= next_sdo;
			wr_stb <= next_wr_stb;
			wdata <= next_wdata;
		end
	end

	assign o_sdo = sdo;
	assign o_wr_stb = wr_stb;
	assign o_wdata = wdata;

	AST_WR_ONLY_AT_CS_RISE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		wr_stb |-> $past(i_cs_n) && !$past(cs_q, 1) && $past(cnt) == 6'(svs_pkg::FRAME_BITS))
		else $error("write strobe without end of full frame");
endmodule // svs_serial_port

//--- svs_supervisor.sv
// supply voltage supervisor: lockout, cutoff and early warning
// Summary of operation
// - regulator lockout set keeps regulator outputs off until both regulator flags clear
// - battery lockout set keeps battery outputs off until both battery flags clear
// - any standby mode ignores both lockouts; outputs restore automatically
// - overvoltage cutoff per rail when its enable bit (21, 19) is one; battery rail also at pump low threshold
// - undervoltage cutoff per rail only when its enable bit (20, 18) is one, or in fail-safe
// - battery overvoltage without cutoff keeps outputs on until pump low threshold
// - rail undervolt dragging main regulator low enters fail-safe, all outputs off
// - active mode, regulator supply below threshold: interrupt low, warning flag set
// - threshold is linear 10-bit; zero disables, all ones is full scale
// - written value applies only when chip select returns high after full frame
module svs_supervisor (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// serial pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_sdi,
	output logic o_sdo,
	// comparator and mode inputs
	input wire logic i_reg_ov,
	input wire logic i_reg_uv,
	input wire logic i_bat_ov,
	input wire logic i_bat_uv,
	input wire logic i_pump_low_threshold,
	input wire logic i_main_regulator_output_uv,
	input wire logic i_active_mode,
	input wire logic i_standby_mode,
	// converter result for the regulator supply rail
	input wire logic i_conv_valid,
	input wire logic [9:0] i_conv_result,
	// flag clears from the status register
	input wire logic i_clr_reg_flags,
	input wire logic i_clr_bat_flags,
	input wire logic i_clr_warning,
	// outputs
	output logic o_reg_rail_outputs_off,
	output logic o_bat_rail_outputs_off,
	output logic o_fail_safe,
	output logic o_interrupt_out_low,
	output logic o_regulator_rail_warning_flag,
	output logic o_regulator_rail_undervolt_flag,
	output logic o_regulator_rail_overvolt_flag,
	output logic o_battery_rail_undervolt_flag,
	output logic o_battery_rail_overvolt_flag,
	output logic [23:0] o_supply_supervision_control
);
	logic [23:0] ctrl, next_ctrl, wdata;
	logic wr_stb;
	logic reg_uv_f, reg_ov_f, bat_uv_f, bat_ov_f, warn_f;
	logic next_reg_uv_f, next_reg_ov_f, next_bat_uv_f, next_bat_ov_f, next_warn_f;
	logic reg_held, bat_held, next_reg_held, next_bat_held;
	logic reg_off, bat_off, fail_safe, next_reg_off, next_bat_off, next_fail_safe;
	logic reg_lock, bat_lock, reg_sd, bat_sd, fs_now, below;
	logic int_n, next_int_n;

	svs_serial_port u_port (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_cs_n(i_cs_n),
		.i_sck(i_sck),
		.i_sdi(i_sdi),
		.o_sdo(o_sdo),
		.i_ctrl(ctrl),
		.o_wr_stb(wr_stb),
		.o_wdata(wdata)
	);

	// fault flag: set wins over clear, kept only under lockout
	function automatic logic flag_next(input logic fault, input logic flag, input logic clr,
		input logic lock);
		flag_next = fault | (flag & ~clr & lock);
	endfunction

	// lockout hold until both flags of the rail are clear
	function automatic logic hold_next(input logic lock, input logic sd, input logic held,
		input logic uv_f, input logic ov_f);
		hold_next = lock & (sd | held) & (uv_f | ov_f);
	endfunction

	// control register update
	always_comb
	begin
		next_ctrl = ctrl;
		if (wr_stb)
			next_ctrl = wdata & svs_pkg::CTRL_WMASK;
	end

	// fault decode and flags
	always_comb
	begin
		reg_lock = ctrl[svs_pkg::REG_LOCK_POS] & ~i_standby_mode;
		bat_lock = ctrl[svs_pkg::BAT_LOCK_POS] & ~i_standby_mode;
		reg_sd = (i_reg_ov & ctrl[svs_pkg::REG_OV_EN_POS])
			| (i_reg_uv & ctrl[svs_pkg::REG_UV_EN_POS]);
		bat_sd = (i_bat_ov & (ctrl[svs_pkg::BAT_OV_EN_POS] | i_pump_low_threshold))
			| (i_bat_uv & ctrl[svs_pkg::BAT_UV_EN_POS]);
		fs_now = (i_reg_uv | i_bat_uv) & i_main_regulator_output_uv;
		// flags: set wins over clear; auto clear without lockout
		next_reg_uv_f = flag_next(i_reg_uv, reg_uv_f, i_clr_reg_flags, reg_lock);
		next_reg_ov_f = flag_next(i_reg_ov, reg_ov_f, i_clr_reg_flags, reg_lock);
		next_bat_uv_f = flag_next(i_bat_uv, bat_uv_f, i_clr_bat_flags, bat_lock);
		next_bat_ov_f = flag_next(i_bat_ov, bat_ov_f, i_clr_bat_flags, bat_lock);
		// lockout hold until both flags of the rail are cleared
		next_reg_held = hold_next(reg_lock, reg_sd, reg_held, next_reg_uv_f, next_reg_ov_f);
		next_bat_held = hold_next(bat_lock, bat_sd, bat_held, next_bat_uv_f, next_bat_ov_f);
		next_fail_safe = fs_now;
		next_reg_off = reg_sd | next_reg_held | fs_now;
		next_bat_off = bat_sd | next_bat_held | fs_now;
	end

	// early warning
	always_comb
	begin
		below = i_conv_valid && (i_conv_result < ctrl[svs_pkg::THR_W-1:0]);
		next_warn_f = warn_f & ~i_clr_warning;
		if (i_active_mode && ctrl[svs_pkg::THR_W-1:0] != svs_pkg::THR_OFF && below)
			next_warn_f = 1'b1;
		next_int_n = ~next_warn_f;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			ctrl <= svs_pkg::CTRL_RESET;
			reg_uv_f <= 1'b0;
			reg_ov_f <= 1'b0;
			bat_uv_f <= 1'b0;
			bat_ov_f <= 1'b0;
			reg_held <= 1'b0;
			bat_held <= 1'b0;
			reg_off <= 1'b0;
			bat_off <= 1'b0;
			fail_safe <= 1'b0;
			warn_f <= 1'b0;
			int_n <= 1'b1;
		end
		else
		begin
			ctrl <= next_ctrl;
			reg_uv_f <= next_reg_uv_f;
			reg_ov_f <= next_reg_ov_f;
			bat_uv_f <= next_bat_uv_f;
			bat_ov_f <= next_bat_ov_f;
			reg_held <= next_reg_held;
			bat_held <= next_bat_held;
			reg_off <= next_reg_off;
			bat_off <= next_bat_off;
			fail_safe <= next_fail_safe;
			warn_f <= next_warn_f;
			int_n <= next_int_n;
		end
	end

	assign o_reg_rail_outputs_off = reg_off;
	assign o_bat_rail_outputs_off = bat_off;
	assign o_fail_safe = fail_safe;
	assign o_interrupt_out_low = int_n;
	assign o_regulator_rail_warning_flag = warn_f;
	assign o_regulator_rail_undervolt_flag = reg_uv_f;
	assign o_regulator_rail_overvolt_flag = reg_ov_f;
	assign o_battery_rail_undervolt_flag = bat_uv_f;
	assign o_battery_rail_overvolt_flag = bat_ov_f;
	assign o_supply_supervision_control = ctrl;

	// checks
	AST_REG_LOCK_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		reg_held && ctrl[svs_pkg::REG_LOCK_POS] && !i_standby_mode && (reg_uv_f || reg_ov_f)
		&& !i_clr_reg_flags |=> reg_off)
		else $error("regulator outputs released while locked out");
	AST_BAT_LOCK_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		bat_held && ctrl[svs_pkg::BAT_LOCK_POS] && !i_standby_mode && (bat_uv_f || bat_ov_f)
		&& !i_clr_bat_flags |=> bat_off)
		else $error("battery outputs released while locked out");
	AST_STANDBY_AUTO_RESTORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_standby_mode |=> !reg_held && !bat_held)
		else $error("lockout held in standby");
	AST_REG_OV_CUTOFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_reg_ov && ctrl[svs_pkg::REG_OV_EN_POS] |=> reg_off)
		else $error("regulator overvoltage cutoff missed");
	AST_BAT_UV_CUTOFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_bat_uv && !ctrl[svs_pkg::BAT_UV_EN_POS] && !i_main_regulator_output_uv
		&& !bat_held && !i_bat_ov && !(ctrl[svs_pkg::BAT_LOCK_POS] && !i_standby_mode)
		|=> !bat_off)
		else $error("battery undervoltage cutoff while disabled");
	AST_PUMP_LOW_CUTOFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_bat_ov && i_pump_low_threshold |=> bat_off)
		else $error("battery outputs kept on below pump threshold");
	AST_FAIL_SAFE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_reg_uv || i_bat_uv) && i_main_regulator_output_uv
		|=> fail_safe && reg_off && bat_off)
		else $error("fail-safe not entered");
	AST_WARN_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_active_mode && i_conv_valid && ctrl[9:0] != 10'h000 && i_conv_result < ctrl[9:0]
		|=> o_interrupt_out_low == 1'b0 && warn_f)
		else $error("early warning not raised");
	AST_THR_ZERO_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!warn_f && ctrl[9:0] == 10'h000 |=> !warn_f)
		else $error("warning raised with threshold zero");
	AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ctrl[17:10] == 8'h00)
		else $error("reserved control bits not zero");
	AST_CTRL_STABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!wr_stb |=> $stable(ctrl))
		else $error("control register changed outside frame end");
	AST_INT_FOLLOWS_WARN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		int_n == !warn_f)
		else $error("interrupt output disagrees with warning flag");
	AST_REG_AUTO_RESTORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!ctrl[svs_pkg::REG_LOCK_POS] && !i_reg_ov && !i_reg_uv && !i_main_regulator_output_uv
		|=> !reg_off && !reg_uv_f && !reg_ov_f)
		else $error("regulator outputs not restored without lockout");
	AST_BAT_AUTO_RESTORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!ctrl[svs_pkg::BAT_LOCK_POS] && !i_bat_ov && !i_bat_uv && !i_main_regulator_output_uv
		|=> !bat_off && !bat_uv_f && !bat_ov_f)
		else $error("battery outputs not restored without lockout");
	AST_BAT_OV_NO_CUTOFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_bat_ov && !ctrl[svs_pkg::BAT_OV_EN_POS] && !i_pump_low_threshold && !i_bat_uv
		&& !bat_held && !i_main_regulator_output_uv
		|=> !bat_off)
		else $error("battery outputs cut while pump still sufficient");
	AST_WARN_NEEDS_VALID: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_conv_valid && !warn_f |=> !warn_f)
		else $error("warning raised without a converter result");
endmodule // svs_supervisor

//--- svs_host.sv
// host-side serial master model for the supervision control register
module svs_host (
	// clock
	input wire logic i_clk,
	// serial pins
	input wire logic i_sdo,
	output logic o_cs_n,
	output logic o_sck,
	output logic o_sdi,
	// read data captured from sdo
	output logic [23:0] o_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
		o_rd_data = '0;
	end
	// send the top n bits of f, msb first; sck stands low outside frames
	task automatic send(input logic [31:0] f, input int n);
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			repeat (2) @(posedge i_clk);
			o_sdi <= f[31 - i];
			repeat (2) @(posedge i_clk);
			o_sck <= 1'b1;
			if (i >= 8)
				o_rd_data <= {o_rd_data[22:0], i_sdo};
			repeat (2) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		repeat (2) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_sdi <= ~o_sdi;
		repeat (3) @(posedge i_clk);
	endtask
endmodule // svs_host

//--- tb_svs_supervisor.sv
// self-checking bench for the supply voltage supervisor
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_svs_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rst_n, pump, main_uv, act, stby, cv, clr_r, clr_b, clr_w, chk_stb;
	logic cs_n, sck, sdi, sdo, reg_off, bat_off, fail, int_n, warn, r_uv, r_ov, b_uv, b_ov;
	logic [3:0] flt;
	logic [9:0] res;
	logic [23:0] ctrl, rdat;
	logic [32:0] expq[$];
	logic [32:0] exp_v;
	logic [31:0] bad_f [3] = '{32'h8333FC05, 32'h0333FC05, 32'h8433FC05};
	int bad_count = 0;
	int checks = 0;
	integer seed = 32'h8236;
	svs_host svs_host_i (.i_clk(i_clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi),
		.o_rd_data(rdat));
	svs_supervisor svs_supervisor_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
		.i_sck(sck), .i_sdi(sdi), .o_sdo(sdo), .i_reg_ov(flt[3]), .i_reg_uv(flt[2]),
		.i_bat_ov(flt[1]), .i_bat_uv(flt[0]), .i_pump_low_threshold(pump),
		.i_main_regulator_output_uv(main_uv), .i_active_mode(act), .i_standby_mode(stby),
		.i_conv_valid(cv), .i_conv_result(res), .i_clr_reg_flags(clr_r),
		.i_clr_bat_flags(clr_b), .i_clr_warning(clr_w), .o_reg_rail_outputs_off(reg_off),
		.o_bat_rail_outputs_off(bat_off), .o_fail_safe(fail), .o_interrupt_out_low(int_n),
		.o_regulator_rail_warning_flag(warn), .o_regulator_rail_undervolt_flag(r_uv),
		.o_regulator_rail_overvolt_flag(r_ov), .o_battery_rail_undervolt_flag(b_uv),
		.o_battery_rail_overvolt_flag(b_ov), .o_supply_supervision_control(ctrl));
	initial forever #5 i_clk = ~i_clk;
	// note an expectation of ctrl and {offs, fail, int, warn, flags}
	task automatic note(input logic [23:0] c, input logic [8:0] s);
		repeat (2) @(posedge i_clk);
		expq.push_back({c, s});
		chk_stb <= 1'b1;
		@(posedge i_clk);
		chk_stb <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// monitor: compare the oldest note against the outputs
	always @(posedge i_clk)
	begin
		if (chk_stb === 1'b1)
		begin
			if (expq.size() == 0)
			begin
				bad_count++;
				$display("ERROR queue expected note seen none");
			end
			else
			begin
				exp_v = expq.pop_front();
				`CHK("outputs", exp_v, {ctrl, reg_off, bat_off, fail, int_n, warn,
					r_uv, r_ov, b_uv, b_ov})
			end
		end
	end
	initial
	begin
		repeat (5000) @(posedge i_clk);
		bad_count++;
		$display("ERROR run expected end seen timeout");
		results();
	end
	initial
	begin
		{i_rst_n, pump, main_uv, act, stby, cv, clr_r, clr_b, clr_w, chk_stb} = '0;
		flt = 4'h0;
		res = 10'h000;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		note(24'hFC0000, 9'h020);
		flt <= 4'hA;
		note(24'hFC0000, 9'h1A5);
		flt <= 4'h0;
		note(24'hFC0000, 9'h1A5);
		clr_r <= 1'b1;
		@(posedge i_clk);
		clr_r <= 1'b0;
		note(24'hFC0000, 9'h0A1);
		clr_b <= 1'b1;
		@(posedge i_clk);
		clr_b <= 1'b0;
		note(24'hFC0000, 9'h020);
		for (int i = 0; i < 3; i++)
		begin
			svs_host_i.send(bad_f[i], i == 0 ? 31 : 32);
			note(24'hFC0000, 9'h020);
		end
		svs_host_i.send(32'h8333FC05, 32);
		note(24'h300005, 9'h020);
		svs_host_i.send(32'h03000000, 32);
		`CHK("read data", 24'h300005, rdat)
		flt <= 4'h8;
		note(24'h300005, 9'h124);
		flt <= 4'h0;
		note(24'h300005, 9'h020);
		flt <= 4'h2;
		note(24'h300005, 9'h021);
		pump <= 1'b1;
		note(24'h300005, 9'h0A1);
		pump <= 1'b0;
		flt <= 4'h1;
		note(24'h300005, 9'h022);
		main_uv <= 1'b1;
		note(24'h300005, 9'h1E2);
		main_uv <= 1'b0;
		flt <= 4'h0;
		note(24'h300005, 9'h020);
		svs_host_i.send(32'h83FC03FF, 32);
		stby <= 1'b1;
		flt <= 4'h8;
		note(24'hFC03FF, 9'h124);
		flt <= 4'h0;
		note(24'hFC03FF, 9'h020);
		stby <= 1'b0;
		act <= 1'b1;
		cv <= 1'b1;
		res <= 10'($random(seed)) & 10'h3FE;
		note(24'hFC03FF, 9'h010);
		res <= 10'h3FF;
		clr_w <= 1'b1;
		@(posedge i_clk);
		clr_w <= 1'b0;
		note(24'hFC03FF, 9'h020);
		act <= 1'b0;
		res <= 10'h000;
		note(24'hFC03FF, 9'h020);
		act <= 1'b1;
		cv <= 1'b0;
		res <= 10'($random(seed)) & 10'h3FE;
		note(24'hFC03FF, 9'h020);
		results();
	end
endmodule // tb_svs_supervisor
